// *** hdl/erdma_pkg.sv ***
// erdma_pkg: register map, field positions, reset values and encodings
// of the expansion ram dma controller.
// assumes byte-wide registers decoded on a 16-bit host address bus.
package erdma_pkg;

	// register byte addresses on the host bus
	localparam logic [15:0] ERDMA_ADDR_STATUS   = 16'hdf00;
	localparam logic [15:0] ERDMA_ADDR_CMD      = 16'hdf01;
	localparam logic [15:0] ERDMA_ADDR_HOST_LO  = 16'hdf02;
	localparam logic [15:0] ERDMA_ADDR_HOST_HI  = 16'hdf03;
	localparam logic [15:0] ERDMA_ADDR_EXP_LO   = 16'hdf04;
	localparam logic [15:0] ERDMA_ADDR_EXP_HI   = 16'hdf05;
	localparam logic [15:0] ERDMA_ADDR_BANK     = 16'hdf06;
	localparam logic [15:0] ERDMA_ADDR_CNT_LO   = 16'hdf07;
	localparam logic [15:0] ERDMA_ADDR_CNT_HI   = 16'hdf08;
	localparam logic [15:0] ERDMA_ADDR_IMASK    = 16'hdf09;
	localparam logic [15:0] ERDMA_ADDR_STEP     = 16'hdf0a;
	localparam logic [15:0] ERDMA_ADDR_CFG_TRIG = 16'hff00;

	// command register fields
	localparam int ERDMA_CMD_EXEC_BIT   = 7;
	localparam int ERDMA_CMD_RELOAD_BIT = 5;
	localparam int ERDMA_CMD_NOTRIG_BIT = 4;
	localparam logic [7:0] ERDMA_CMD_WR_MASK = 8'hb3;

	// interrupt mask fields
	localparam int ERDMA_IM_ENABLE_BIT = 7;
	localparam int ERDMA_IM_EOB_BIT    = 6;
	localparam int ERDMA_IM_FAULT_BIT  = 5;
	localparam logic [7:0] ERDMA_IM_WR_MASK = 8'he0;

	// address step control fields
	localparam int ERDMA_STEP_HOLD_HOST_BIT = 7;
	localparam int ERDMA_STEP_HOLD_EXP_BIT  = 6;
	localparam logic [7:0] ERDMA_STEP_WR_MASK = 8'hc0;

	// status fields
	localparam int ERDMA_ST_PEND_BIT  = 7;
	localparam int ERDMA_ST_EOB_BIT   = 6;
	localparam int ERDMA_ST_FAULT_BIT = 5;
	localparam int ERDMA_ST_SIZE_BIT  = 4;

	// widths and reset values
	localparam int ERDMA_BANK_BITS = 3;
	localparam int ERDMA_EXP_BITS  = 16 + ERDMA_BANK_BITS;
	localparam logic [7:0] ERDMA_REG_RESET = 8'h00;

	// operation field of the command register
	typedef enum logic [1:0]
	{
		ERDMA_OP_TO_EXP   = 2'b00,
		ERDMA_OP_TO_HOST  = 2'b01,
		ERDMA_OP_SWAP     = 2'b10,
		ERDMA_OP_VERIFY   = 2'b11
	} erdma_op_t;

	// transfer sequencer states
	typedef enum logic [2:0]
	{
		ERDMA_ST_IDLE    = 3'b000,
		ERDMA_ST_ARMED   = 3'b001,
		ERDMA_ST_HOST_RD = 3'b010,
		ERDMA_ST_EXP_RD  = 3'b011,
		ERDMA_ST_EXP_WR  = 3'b100,
		ERDMA_ST_HOST_WR = 3'b101,
		ERDMA_ST_STEP    = 3'b110
	} erdma_state_t;

endpackage

// *** hdl/erdma_sync.sv ***
// erdma_sync: two-flop synchroniser for levels from outside the clock domain.
// assumes the input is a slow level; no pulse is guaranteed to pass.
`timescale 1ns/10ps
`default_nettype none
module erdma_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             sys_clk,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_ff;
	logic [WIDTH-1:0] sync_ff;

	// first stage is read only by the second stage
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			meta_ff <= '0;
			sync_ff <= '0;
		end
		else
		begin
			meta_ff <= async_in;
			sync_ff <= meta_ff;
		end
	end

	assign sync_out = sync_ff;
endmodule
`default_nettype wire

// *** hdl/erdma_step_ctr.sv ***
// erdma_step_ctr: loadable up/down counter used for addresses and byte count.
// assumes load and step never need to act in the same cycle; load wins.
`timescale 1ns/10ps
`default_nettype none
module erdma_step_ctr #(
	parameter int WIDTH = 16
) (
	input  wire logic             sys_clk,
	input  wire logic             rst,
	input  wire logic             load,
	input  wire logic [WIDTH-1:0] load_val,
	input  wire logic             step,
	input  wire logic             down,
	output logic      [WIDTH-1:0] value
);
	logic [WIDTH-1:0] value_ff;
	logic [WIDTH-1:0] nxt_value;

	// wraps silently at both ends, as a plain byte pointer would
	assign nxt_value = load ? load_val :
	                   step ? (down ? value_ff - 1'b1 : value_ff + 1'b1) : value_ff;

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			value_ff <= '0;
		else
			value_ff <= nxt_value;
	end

	assign value = value_ff;
endmodule
`default_nettype wire

// *** hdl/erdma_ctrl.sv ***
// erdma_ctrl: expansion ram dma controller, register file and byte sequencer.
// assumes a single-cycle host register port and memories answering with a one-cycle ack.
// Function
// - command bit 7 starts the programmed transfer
// - auto-reload restores addresses and count after transfer
// - command bit 4 disables the ff00 trigger
// - bits 1-0 pick copy, reverse, swap, verify
// - host address from df02 low, df03 high
// - expansion address from df04 low, df05 high
// - bank bits 2-0 pick 64k expansion bank
// - byte count from df07 low, df08 high
// - mask bit 7 gates every interrupt
// - mask bit 6 interrupts on end of block
// - mask bit 5 interrupts on verify mismatch
// - step control bits 7,6 hold either address
// - status bit 7 shows interrupt pending
// - status bit 6 shows transfer complete
// - status bit 5 shows verify mismatch
// - status bit 4 size, bits 3-0 version
`timescale 1ns/10ps
`default_nettype none
module erdma_ctrl #(
	parameter logic [3:0] VERSION = 4'h1 // arbitrary version value
) (
	input  wire logic                           sys_clk,
	input  wire logic                           rst,
	input  wire logic [15:0]                    reg_addr,
	input  wire logic [7:0]                     reg_wdata,
	input  wire logic                           reg_wr,
	input  wire logic                           reg_rd,
	output logic      [7:0]                     reg_rdata,
	output logic                                host_mem_req,
	output logic                                host_mem_we,
	output logic      [15:0]                    host_mem_addr,
	output logic      [7:0]                     host_mem_wdata,
	input  wire logic [7:0]                     host_mem_rdata,
	input  wire logic                           host_mem_ack,
	output logic                                exp_mem_req,
	output logic                                exp_mem_we,
	output logic      [erdma_pkg::ERDMA_EXP_BITS-1:0] exp_mem_addr,
	output logic      [7:0]                     exp_mem_wdata,
	input  wire logic [7:0]                     exp_mem_rdata,
	input  wire logic                           exp_mem_ack,
	input  wire logic                           exp_size_pin,
	output logic                                busy,
	output logic                                irq
);
	import erdma_pkg::*;

	// true when the bus address hits the given register
	function automatic logic hit(input logic [15:0] a, input logic [15:0] off);
		hit = (a == off);
	endfunction

	erdma_state_t state_ff;
	erdma_state_t nxt_state;
	erdma_op_t    op_ff;
	logic [7:0] cmd_ff;
	logic [7:0] host_lo_ff;
	logic [7:0] host_hi_ff;
	logic [7:0] exp_lo_ff;
	logic [7:0] exp_hi_ff;
	logic [7:0] bank_ff;
	logic [7:0] cnt_lo_ff;
	logic [7:0] cnt_hi_ff;
	logic [7:0] imask_ff;
	logic [7:0] stepc_ff;
	logic       eob_ff;
	logic       fault_ff;
	logic       load_ff;
	logic [7:0] hold_a_ff;
	logic [7:0] hold_b_ff;
	logic [7:0] rdata_ff;

	// write strobes and the status read strobe
	wire wr_cmd    = reg_wr & hit(reg_addr, ERDMA_ADDR_CMD);
	wire wr_trig   = reg_wr & hit(reg_addr, ERDMA_ADDR_CFG_TRIG);
	wire wr_ptrs   = reg_wr & (hit(reg_addr, ERDMA_ADDR_HOST_LO) | hit(reg_addr, ERDMA_ADDR_HOST_HI) |
	                           hit(reg_addr, ERDMA_ADDR_EXP_LO)  | hit(reg_addr, ERDMA_ADDR_EXP_HI)  |
	                           hit(reg_addr, ERDMA_ADDR_BANK)    | hit(reg_addr, ERDMA_ADDR_CNT_LO)  |
	                           hit(reg_addr, ERDMA_ADDR_CNT_HI));
	wire rd_status = reg_rd & hit(reg_addr, ERDMA_ADDR_STATUS);

	// start decode: immediate when the ff00 trigger is disabled, else armed
	wire idle_st   = (state_ff == ERDMA_ST_IDLE);
	wire go_now    = idle_st & wr_cmd & reg_wdata[ERDMA_CMD_EXEC_BIT] & reg_wdata[ERDMA_CMD_NOTRIG_BIT];
	wire go_arm    = idle_st & wr_cmd & reg_wdata[ERDMA_CMD_EXEC_BIT] & ~reg_wdata[ERDMA_CMD_NOTRIG_BIT];
	wire go_trig   = (state_ff == ERDMA_ST_ARMED) & wr_trig;
	wire start     = go_now | go_trig;
	erdma_op_t start_op;
	assign start_op = go_now ? erdma_op_t'(reg_wdata[1:0]) : op_ff;

	// memory answers and byte compare
	wire host_done = host_mem_req & host_mem_ack;
	wire exp_done  = exp_mem_req & exp_mem_ack;
	wire step_st   = (state_ff == ERDMA_ST_STEP);
	wire mismatch  = (state_ff == ERDMA_ST_EXP_RD) & exp_done & (op_ff == ERDMA_OP_VERIFY) &
	                 (exp_mem_rdata != hold_a_ff);

	logic [15:0] cnt_val;
	logic [15:0] host_val;
	wire last_byte = step_st & (cnt_val == 16'h0001);
	wire finish    = last_byte | mismatch;
	wire reload    = finish & cmd_ff[ERDMA_CMD_RELOAD_BIT];

	// first access of each byte depends on direction
	function automatic erdma_state_t first_state(input erdma_op_t op);
		first_state = (op == ERDMA_OP_TO_HOST) ? ERDMA_ST_EXP_RD : ERDMA_ST_HOST_RD;
	endfunction

	// sequencer next state
	always_comb
	begin
		nxt_state = state_ff;
		case (state_ff)
			ERDMA_ST_IDLE:
				if (go_now)
					nxt_state = first_state(start_op);
				else if (go_arm)
					nxt_state = ERDMA_ST_ARMED;
			ERDMA_ST_ARMED:
				if (go_trig)
					nxt_state = first_state(op_ff);
			ERDMA_ST_HOST_RD:
				if (host_done)
					nxt_state = (op_ff == ERDMA_OP_TO_EXP) ? ERDMA_ST_EXP_WR : ERDMA_ST_EXP_RD;
			ERDMA_ST_EXP_RD:
				if (exp_done)
				begin
					case (op_ff)
						ERDMA_OP_TO_HOST: nxt_state = ERDMA_ST_HOST_WR;
						ERDMA_OP_SWAP:    nxt_state = ERDMA_ST_EXP_WR;
						default:          nxt_state = mismatch ? ERDMA_ST_IDLE : ERDMA_ST_STEP;
					endcase
				end
			ERDMA_ST_EXP_WR:
				if (exp_done)
					nxt_state = (op_ff == ERDMA_OP_SWAP) ? ERDMA_ST_HOST_WR : ERDMA_ST_STEP;
			ERDMA_ST_HOST_WR:
				if (host_done)
					nxt_state = ERDMA_ST_STEP;
			ERDMA_ST_STEP:
				nxt_state = last_byte ? ERDMA_ST_IDLE : first_state(op_ff);
			default:
				nxt_state = ERDMA_ST_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			state_ff <= ERDMA_ST_IDLE;
			op_ff    <= ERDMA_OP_TO_EXP;
		end
		else
		begin
			state_ff <= nxt_state;
			if (go_now | go_arm)
				op_ff <= erdma_op_t'(reg_wdata[1:0]);
		end
	end

	// programmed values; reserved command bits are dropped on write
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			cmd_ff     <= ERDMA_REG_RESET;
			host_lo_ff <= ERDMA_REG_RESET;
			host_hi_ff <= ERDMA_REG_RESET;
			exp_lo_ff  <= ERDMA_REG_RESET;
			exp_hi_ff  <= ERDMA_REG_RESET;
			bank_ff    <= ERDMA_REG_RESET;
			cnt_lo_ff  <= ERDMA_REG_RESET;
			cnt_hi_ff  <= ERDMA_REG_RESET;
			imask_ff   <= ERDMA_REG_RESET;
			stepc_ff   <= ERDMA_REG_RESET;
		end
		else
		begin
			if (wr_cmd & idle_st)
				cmd_ff <= reg_wdata & ERDMA_CMD_WR_MASK;
			else if (finish)
				cmd_ff[ERDMA_CMD_EXEC_BIT] <= 1'b0;
			if (reg_wr & hit(reg_addr, ERDMA_ADDR_HOST_LO)) host_lo_ff <= reg_wdata;
			if (reg_wr & hit(reg_addr, ERDMA_ADDR_HOST_HI)) host_hi_ff <= reg_wdata;
			if (reg_wr & hit(reg_addr, ERDMA_ADDR_EXP_LO))  exp_lo_ff  <= reg_wdata;
			if (reg_wr & hit(reg_addr, ERDMA_ADDR_EXP_HI))  exp_hi_ff  <= reg_wdata;
			if (reg_wr & hit(reg_addr, ERDMA_ADDR_BANK))    bank_ff    <= {5'h00, reg_wdata[2:0]};
			if (reg_wr & hit(reg_addr, ERDMA_ADDR_CNT_LO))  cnt_lo_ff  <= reg_wdata;
			if (reg_wr & hit(reg_addr, ERDMA_ADDR_CNT_HI))  cnt_hi_ff  <= reg_wdata;
			if (reg_wr & hit(reg_addr, ERDMA_ADDR_IMASK))   imask_ff   <= reg_wdata & ERDMA_IM_WR_MASK;
			if (reg_wr & hit(reg_addr, ERDMA_ADDR_STEP))    stepc_ff   <= reg_wdata & ERDMA_STEP_WR_MASK;
		end
	end

	// live counters reload one cycle after a pointer write while idle, or after auto-reload;
	// pointer writes during a transfer only change the programmed copy
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			load_ff <= 1'b0;
		else
			load_ff <= (wr_ptrs & idle_st) | reload;
	end

	wire hold_host = stepc_ff[ERDMA_STEP_HOLD_HOST_BIT];
	wire hold_exp  = stepc_ff[ERDMA_STEP_HOLD_EXP_BIT];

	erdma_step_ctr #(.WIDTH(16)) u_host_ctr (
		.sys_clk  (sys_clk),
		.rst      (rst),
		.load     (load_ff),
		.load_val ({host_hi_ff, host_lo_ff}),
		.step     (step_st & ~last_byte & ~hold_host),
		.down     (1'b0),
		.value    (host_val)
	);

	erdma_step_ctr #(.WIDTH(ERDMA_EXP_BITS)) u_exp_ctr (
		.sys_clk  (sys_clk),
		.rst      (rst),
		.load     (load_ff),
		.load_val ({bank_ff[ERDMA_BANK_BITS-1:0], exp_hi_ff, exp_lo_ff}),
		.step     (step_st & ~last_byte & ~hold_exp),
		.down     (1'b0),
		.value    (exp_mem_addr)
	);

	// a count of zero runs 65536 bytes since it wraps before reaching one
	erdma_step_ctr #(.WIDTH(16)) u_cnt_ctr (
		.sys_clk  (sys_clk),
		.rst      (rst),
		.load     (load_ff),
		.load_val ({cnt_hi_ff, cnt_lo_ff}),
		.step     (step_st & ~last_byte),
		.down     (1'b1),
		.value    (cnt_val)
	);

	// byte holding registers: a is the host byte, b the expansion byte
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			hold_a_ff <= 8'h00;
			hold_b_ff <= 8'h00;
		end
		else
		begin
			if ((state_ff == ERDMA_ST_HOST_RD) & host_done)
				hold_a_ff <= host_mem_rdata;
			if ((state_ff == ERDMA_ST_EXP_RD) & exp_done)
				hold_b_ff <= exp_mem_rdata;
		end
	end

	// memory strobes
	assign host_mem_req   = (state_ff == ERDMA_ST_HOST_RD) | (state_ff == ERDMA_ST_HOST_WR);
	assign host_mem_we    = (state_ff == ERDMA_ST_HOST_WR);
	assign host_mem_addr  = host_val;
	assign host_mem_wdata = hold_b_ff;
	assign exp_mem_req    = (state_ff == ERDMA_ST_EXP_RD) | (state_ff == ERDMA_ST_EXP_WR);
	assign exp_mem_we     = (state_ff == ERDMA_ST_EXP_WR);
	assign exp_mem_wdata  = hold_a_ff;
	assign busy           = ~idle_st;

	// event flags; a status read clears them but a new event in that cycle wins
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			eob_ff   <= 1'b0;
			fault_ff <= 1'b0;
		end
		else
		begin
			eob_ff   <= finish | (eob_ff & ~rd_status);
			fault_ff <= mismatch | (fault_ff & ~rd_status);
		end
	end

	// interrupt request and pending bit share one term
	wire pending = imask_ff[ERDMA_IM_ENABLE_BIT] &
	               ((eob_ff & imask_ff[ERDMA_IM_EOB_BIT]) | (fault_ff & imask_ff[ERDMA_IM_FAULT_BIT]));
	assign irq = pending;

	logic size_512k;
	erdma_sync #(.WIDTH(1)) u_size_sync (
		.sys_clk  (sys_clk),
		.rst      (rst),
		.async_in (exp_size_pin),
		.sync_out (size_512k)
	);

	// read mux; unmapped addresses answer zero
	wire [7:0] status_word = {pending, eob_ff, fault_ff, size_512k, VERSION};
	logic [7:0] rd_mux;
	always_comb
	begin
		case (reg_addr)
			ERDMA_ADDR_STATUS:  rd_mux = status_word;
			ERDMA_ADDR_CMD:     rd_mux = cmd_ff;
			ERDMA_ADDR_HOST_LO: rd_mux = host_val[7:0];
			ERDMA_ADDR_HOST_HI: rd_mux = host_val[15:8];
			ERDMA_ADDR_EXP_LO:  rd_mux = exp_mem_addr[7:0];
			ERDMA_ADDR_EXP_HI:  rd_mux = exp_mem_addr[15:8];
			ERDMA_ADDR_BANK:    rd_mux = {5'h00, exp_mem_addr[ERDMA_EXP_BITS-1:16]};
			ERDMA_ADDR_CNT_LO:  rd_mux = cnt_val[7:0];
			ERDMA_ADDR_CNT_HI:  rd_mux = cnt_val[15:8];
			ERDMA_ADDR_IMASK:   rd_mux = imask_ff;
			ERDMA_ADDR_STEP:    rd_mux = stepc_ff;
			default:            rd_mux = 8'h00;
		endcase
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			rdata_ff <= 8'h00;
		else if (reg_rd)
			rdata_ff <= rd_mux;
	end
	assign reg_rdata = rdata_ff;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	sequence host_byte_read_s;
		(state_ff == ERDMA_ST_HOST_RD) && host_done && (op_ff == ERDMA_OP_TO_EXP);
	endsequence
	sequence exp_byte_write_s;
		(state_ff == ERDMA_ST_EXP_WR) && exp_mem_we;
	endsequence

	start_now_a: assert property (go_now |=> (state_ff == ERDMA_ST_HOST_RD || state_ff == ERDMA_ST_EXP_RD))
		else $error("exec with trigger disabled did not start");
	armed_wait_a: assert property (go_arm |=> (state_ff == ERDMA_ST_ARMED) && !host_mem_req && !exp_mem_req)
		else $error("exec with trigger enabled did not wait");
	copy_order_a: assert property (host_byte_read_s |=> exp_byte_write_s)
		else $error("copy to expansion did not write expansion next");
	reload_ptr_a: assert property (reload && !wr_ptrs |-> ##2 host_val == $past(({host_hi_ff, host_lo_ff}), 2))
		else $error("auto reload did not restore host address");
	hold_host_a: assert property (step_st && hold_host |=> host_val == $past(host_val))
		else $error("held host address moved");
	irq_gate_a: assert property (!imask_ff[ERDMA_IM_ENABLE_BIT] |-> !irq)
		else $error("interrupt raised while globally disabled");
	eob_irq_a: assert property (finish && imask_ff[7] && imask_ff[6] && !reg_wr |=> irq && status_word[7])
		else $error("end of block did not interrupt");
	fault_irq_a: assert property (mismatch && imask_ff[7] && imask_ff[5] && !reg_wr |=> irq && fault_ff)
		else $error("verify mismatch did not interrupt");
	eob_flag_a: assert property (last_byte |=> eob_ff && idle_st && !cmd_ff[7])
		else $error("completion not reported");
	pend_bit_a: assert property (rd_status |=> reg_rdata[ERDMA_ST_PEND_BIT] == $past(irq))
		else $error("pending bit read back disagrees with interrupt line");
endmodule
`default_nettype wire

// *** sim/erdma_mem_model.sv ***
// erdma_mem_model: byte-wide memory behind a req/ack port, host or expansion side.
// assumes the requester holds req, we, addr and wdata until it samples ack.
`timescale 1ns/10ps
`default_nettype none
module erdma_mem_model #(
	parameter int AW = 16
) (
	input  wire logic          sys_clk,
	input  wire logic          rst,
	input  wire logic          slow,
	input  wire logic          req,
	input  wire logic          we,
	input  wire logic [AW-1:0] addr,
	input  wire logic [7:0]    wdata,
	output logic      [7:0]    rdata,
	output logic               ack
);
	logic [7:0] mem [0:(1<<AW)-1];
	logic [2:0] wait_ff;

	// slow mode stretches each access; rdata toggles outside the ack cycle
	// so a requester that samples late never sees a stale byte by luck
	always @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			ack     <= 1'b0;
			wait_ff <= 3'h0;
			rdata   <= 8'h00;
		end
		else if (req && !ack && wait_ff >= (slow ? 3'h4 : 3'h0))
		begin
			ack     <= 1'b1;
			wait_ff <= 3'h0;
			rdata   <= mem[addr];
			if (we)
				mem[addr] <= wdata;
		end
		else
		begin
			ack     <= 1'b0;
			wait_ff <= (req && !ack) ? wait_ff + 3'h1 : 3'h0;
			rdata   <= ~rdata;
		end
	end
endmodule
`default_nettype wire

// *** sim/tb_expansion_ram_dma_controller.sv ***
// tb_expansion_ram_dma_controller: register-level regression of the dma engine.
// assumes two req/ack memory models and a 10 MHz clock; inputs move at falling edges.
`timescale 1ns/10ps
`default_nettype none
module tb_expansion_ram_dma_controller;
	import erdma_pkg::*;
	localparam logic [3:0] VER = 4'h1; // arbitrary version value
	logic                      sys_clk, rst, reg_wr, reg_rd, size_pin, slow;
	logic                      h_req, h_we, h_ack, e_req, e_we, e_ack, busy, irq;
	logic [15:0]               reg_addr, h_addr;
	logic [7:0]                reg_wdata, reg_rdata, h_rd, h_wd, e_rd, e_wd;
	logic [ERDMA_EXP_BITS-1:0] e_addr;
	int                        errors, n_checks, i;

	erdma_ctrl #(.VERSION(VER)) DUT (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.host_mem_req(h_req), .host_mem_we(h_we), .host_mem_addr(h_addr), .host_mem_wdata(h_wd),
		.host_mem_rdata(h_rd), .host_mem_ack(h_ack), .exp_mem_req(e_req), .exp_mem_we(e_we),
		.exp_mem_addr(e_addr), .exp_mem_wdata(e_wd), .exp_mem_rdata(e_rd), .exp_mem_ack(e_ack),
		.exp_size_pin(size_pin), .busy(busy), .irq(irq));
	erdma_mem_model #(.AW(16)) hmem (.sys_clk(sys_clk), .rst(rst), .slow(slow), .req(h_req),
		.we(h_we), .addr(h_addr), .wdata(h_wd), .rdata(h_rd), .ack(h_ack));
	erdma_mem_model #(.AW(ERDMA_EXP_BITS)) emem (.sys_clk(sys_clk), .rst(rst), .slow(slow),
		.req(e_req), .we(e_we), .addr(e_addr), .wdata(e_wd), .rdata(e_rd), .ack(e_ack));

	// 100 ns clock
	initial
	begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end

	task automatic tally_and_finish();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// one-cycle write strobe
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(negedge sys_clk);
		reg_addr  = a;
		reg_wdata = d;
		reg_wr    = 1'b1;
		@(negedge sys_clk);
		reg_wr = 1'b0;
	endtask

	// read data lands one cycle after the strobe edge
	task automatic rchk(input string what, input logic [15:0] a, input logic [7:0] e);
		@(negedge sys_clk);
		reg_addr = a;
		reg_rd   = 1'b1;
		@(negedge sys_clk);
		reg_rd = 1'b0;
		chk(what, reg_rdata, e);
	endtask

	task automatic prog(input logic [15:0] h, input logic [18:0] e, input logic [15:0] n,
		input logic [7:0] st);
		wr(ERDMA_ADDR_HOST_LO, h[7:0]);
		wr(ERDMA_ADDR_HOST_HI, h[15:8]);
		wr(ERDMA_ADDR_EXP_LO, e[7:0]);
		wr(ERDMA_ADDR_EXP_HI, e[15:8]);
		wr(ERDMA_ADDR_BANK, {5'h00, e[18:16]});
		wr(ERDMA_ADDR_CNT_LO, n[7:0]);
		wr(ERDMA_ADDR_CNT_HI, n[15:8]);
		wr(ERDMA_ADDR_STEP, st);
	endtask

	// bounded wait for idle, then room for eob and reload to settle
	task automatic wait_idle();
		int k;
		for (k = 0; k < 3000 && busy !== 1'b0; k++)
			@(negedge sys_clk);
		if (busy !== 1'b0)
		begin
			errors++;
			tally_and_finish();
		end
		repeat (4) @(negedge sys_clk);
	endtask

	task automatic run(input logic [7:0] cmd);
		wr(ERDMA_ADDR_CMD, cmd);
		wait_idle();
	endtask

	initial
	begin
		errors    = 0;
		n_checks  = 0;
		rst       = 1'b1;
		reg_wr    = 1'b0;
		reg_rd    = 1'b0;
		reg_addr  = 16'h0000;
		reg_wdata = 8'h00;
		size_pin  = 1'b1;
		slow      = 1'b0;
		repeat (16) @(negedge sys_clk);
		rst = 1'b0;
		// the size strap needs two edges through its synchroniser
		repeat (2) @(negedge sys_clk);
		// reset values, unmapped read
		rchk("status", ERDMA_ADDR_STATUS, {4'h1, VER});
		for (i = 1; i <= 11; i++)
			rchk("reset reg", 16'hdf00 + 16'(i), 8'h00);
		// reserved and unused bits read back zero
		wr(ERDMA_ADDR_CMD, 8'h4c);
		rchk("cmd reserved", ERDMA_ADDR_CMD, 8'h00);
		wr(ERDMA_ADDR_IMASK, 8'hff);
		rchk("imask", ERDMA_ADDR_IMASK, 8'he0);
		wr(ERDMA_ADDR_STEP, 8'hff);
		rchk("step", ERDMA_ADDR_STEP, 8'hc0);
		wr(ERDMA_ADDR_BANK, 8'hff);
		rchk("bank", ERDMA_ADDR_BANK, 8'h07);
		wr(ERDMA_ADDR_IMASK, 8'h00);
		// host to expansion, four bytes into bank 3
		for (i = 0; i < 4; i++)
			hmem.mem[16'h1234 + 16'(i)] = 8'ha0 + 8'(i);
		prog(16'h1234, 19'h35678, 16'h0004, 8'h00);
		run(8'h90);
		for (i = 0; i < 4; i++)
			chk("copy out", emem.mem[19'h35678 + 19'(i)], 8'ha0 + 8'(i));
		rchk("host lo live", ERDMA_ADDR_HOST_LO, 8'h37);
		rchk("host hi live", ERDMA_ADDR_HOST_HI, 8'h12);
		rchk("exp lo live", ERDMA_ADDR_EXP_LO, 8'h7b);
		rchk("count live", ERDMA_ADDR_CNT_LO, 8'h01);
		chk("irq masked", {7'h00, irq}, 8'h00);
		rchk("status eob", ERDMA_ADDR_STATUS, {4'h5, VER});
		rchk("status clr", ERDMA_ADDR_STATUS, {4'h1, VER});
		// expansion to host, slow memories, host address held
		slow = 1'b1;
		hmem.mem[16'h2001] = 8'h55;
		for (i = 0; i < 3; i++)
			emem.mem[19'h00100 + 19'(i)] = 8'hc0 + 8'(i);
		prog(16'h2000, 19'h00100, 16'h0003, 8'h80);
		run(8'h91);
		chk("held host", hmem.mem[16'h2000], 8'hc2);
		chk("untouched", hmem.mem[16'h2001], 8'h55);
		rchk("exp lo step", ERDMA_ADDR_EXP_LO, 8'h02);
		slow = 1'b0;
		// swap two bytes with bank 1
		hmem.mem[16'h3000] = 8'h11;
		hmem.mem[16'h3001] = 8'h22;
		emem.mem[19'h10200] = 8'h33;
		emem.mem[19'h10201] = 8'h44;
		prog(16'h3000, 19'h10200, 16'h0002, 8'h00);
		run(8'h92);
		chk("swap h0", hmem.mem[16'h3000], 8'h33);
		chk("swap h1", hmem.mem[16'h3001], 8'h44);
		chk("swap e0", emem.mem[19'h10200], 8'h11);
		chk("swap e1", emem.mem[19'h10201], 8'h22);
		// verify finds a difference at the second byte
		for (i = 0; i < 3; i++)
		begin
			hmem.mem[16'h4000 + 16'(i)] = 8'h10 * 8'(i + 1);
			emem.mem[19'h20000 + 19'(i)] = 8'h10 * 8'(i + 1);
		end
		emem.mem[19'h20001] = 8'h21;
		wr(ERDMA_ADDR_IMASK, 8'ha0);
		prog(16'h4000, 19'h20000, 16'h0003, 8'h00);
		run(8'h93);
		chk("irq fault", {7'h00, irq}, 8'h01);
		rchk("host stop", ERDMA_ADDR_HOST_LO, 8'h01);
		rchk("status flt", ERDMA_ADDR_STATUS, {4'hf, VER});
		chk("irq cleared", {7'h00, irq}, 8'h00);
		// equal data with global enable off
		wr(ERDMA_ADDR_IMASK, 8'h60);
		prog(16'h4000, 19'h20000, 16'h0001, 8'h00);
		run(8'h93);
		chk("irq off", {7'h00, irq}, 8'h00);
		rchk("status ok", ERDMA_ADDR_STATUS, {4'h5, VER});
		// armed until the trigger address is written, then auto-reload
		hmem.mem[16'h5000] = 8'h77;
		hmem.mem[16'h5001] = 8'h88;
		wr(ERDMA_ADDR_IMASK, 8'hc0);
		prog(16'h5000, 19'h30000, 16'h0002, 8'h00);
		wr(ERDMA_ADDR_CMD, 8'ha0);
		repeat (6) @(negedge sys_clk);
		chk("armed busy", {7'h00, busy}, 8'h01);
		chk("armed idle", {7'h00, h_req}, 8'h00);
		wr(ERDMA_ADDR_CFG_TRIG, 8'h00);
		wait_idle();
		chk("trig e0", emem.mem[19'h30000], 8'h77);
		chk("trig e1", emem.mem[19'h30001], 8'h88);
		chk("irq eob", {7'h00, irq}, 8'h01);
		rchk("cnt reload", ERDMA_ADDR_CNT_LO, 8'h02);
		rchk("host reload", ERDMA_ADDR_HOST_LO, 8'h00);
		rchk("exec clear", ERDMA_ADDR_CMD, 8'h20);
		rchk("status pend", ERDMA_ADDR_STATUS, {4'hd, VER});
		// expansion address held, host address steps
		hmem.mem[16'h6000] = 8'h5a;
		hmem.mem[16'h6001] = 8'ha5;
		prog(16'h6000, 19'h40000, 16'h0002, 8'h40);
		run(8'h90);
		chk("held exp", emem.mem[19'h40000], 8'ha5);
		rchk("exp lo held", ERDMA_ADDR_EXP_LO, 8'h00);
		rchk("host lo step", ERDMA_ADDR_HOST_LO, 8'h01);
		// small expansion strapped; give the synchroniser time
		size_pin = 1'b0;
		repeat (3) @(negedge sys_clk);
		rchk("status 128k", ERDMA_ADDR_STATUS, {4'hc, VER});
		tally_and_finish();
	end
endmodule
`default_nettype wire
